// >>> src/bit_and_flag_instruction_unit.sv
// Bit, shift and status flag instruction datapath with an Avalon-MM slave
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module bit_and_flag_instruction_unit
    import bitflag_pkg::*;
(
    input  wire logic              clk,               // 125 MHz clock
    input  wire logic              rst_n,             // Asynchronous reset
    input  wire logic [ADDR_W-1:0] address,           // Byte address
    input  wire logic              read,              // Read request
    input  wire logic              write,             // Write request
    input  wire logic [3:0]        byteenable,        // Byte lanes
    input  wire logic [31:0]       writedata,         // Write data
    output logic      [31:0]       readdata,          // Read data
    output logic                   waitrequest,       // Stall request
    output logic      [7:0]        dest_value,        // Destination register
    output logic      [7:0]        status_value,      // Status register
    output logic                   global_irq_enable  // Interrupt enable bit
);

    // ==========================================
    // Reset synchroniser
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ==========================================
    // Instruction execution
    function automatic exec_t execute(
        input insn_t      i,
        input logic [7:0] d,
        input logic [7:0] s,
        input logic [7:0] r
    );
        exec_t      o;
        logic [7:0] res;
        logic       c;
        logic       shift;
        o     = '{dest: d, status: s};
        res   = d;
        c     = s[FLAG_C];
        shift = 1'b0;
        case (i.op)
            OP_LOGICAL_SHIFT_RIGHT: begin
                res   = {1'b0, d[7:1]};
                c     = d[0];
                shift = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY: begin
                res   = {d[6:0], s[FLAG_C]};
                c     = d[7];
                shift = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                res   = {s[FLAG_C], d[7:1]};
                c     = d[0];
                shift = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT: begin
                res   = {d[7], d[7:1]};
                c     = d[0];
                shift = 1'b1;
            end
            OP_SWAP: o.dest = {d[3:0], d[7:4]};
            OP_STATUS_BIT_SET: o.status[i.bit_idx] = 1'b1;
            OP_STATUS_BIT_CLEAR: o.status[i.bit_idx] = 1'b0;
            OP_STORE_BIT_TO_TRANSFER: o.status[FLAG_T] = r[i.bit_idx];
            OP_LOAD_BIT_FROM_TRANSFER: o.dest[i.bit_idx] = s[FLAG_T];
            OP_SETC: o.status[FLAG_C] = 1'b1;
            OP_CLRC: o.status[FLAG_C] = 1'b0;
            OP_SETN: o.status[FLAG_N] = 1'b1;
            OP_CLRN: o.status[FLAG_N] = 1'b0;
            OP_SETZ: o.status[FLAG_Z] = 1'b1;
            OP_CLRZ: o.status[FLAG_Z] = 1'b0;
            OP_IRQE: o.status[FLAG_I] = 1'b1;
            OP_IRQD: o.status[FLAG_I] = 1'b0;
            OP_SETS: o.status[FLAG_S] = 1'b1;
            OP_CLRS: o.status[FLAG_S] = 1'b0;
            OP_SETV: o.status[FLAG_V] = 1'b1;
            OP_CLRV: o.status[FLAG_V] = 1'b0;
            OP_SETT: o.status[FLAG_T] = 1'b1;
            OP_CLRT: o.status[FLAG_T] = 1'b0;
            OP_SETH: o.status[FLAG_H] = 1'b1;
            OP_CLRH: o.status[FLAG_H] = 1'b0;
            default: o = '{dest: d, status: s};
        endcase
        if (shift) begin
            o.dest           = res;
            o.status[FLAG_C] = c;
            o.status[FLAG_Z] = (res == 8'h00);
            o.status[FLAG_N] = res[7];
            o.status[FLAG_V] = res[7] ^ c;
        end
        return o;
    endfunction

    // ==========================================
    // Address decode
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [4:0]        ofs
    );
        return a == ofs;
    endfunction

    // ==========================================
    // Avalon slave handshake, one wait state
    bus_state_t bus_state;
    logic       request;
    logic       accept;
    logic       wr_lane;

    assign request     = read | write;
    assign waitrequest = request && (bus_state == BUS_IDLE);
    assign accept      = request && (bus_state == BUS_ANSWER);
    assign wr_lane     = accept && write && byteenable[0];

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (request) begin
                        bus_state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: bus_state <= BUS_IDLE;
                default:    bus_state <= BUS_IDLE;
            endcase
        end
    end

    // ==========================================
    // Registers
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] status;
    logic [7:0] insn;
    insn_t      wr_insn;
    exec_t      exec_now;
    logic       exec_fire;

    assign wr_insn   = insn_t'(writedata[7:0]);
    assign exec_now  = execute(wr_insn, dest, status, src);
    assign exec_fire = wr_lane && hit(address, OFS_INSN);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dest <= RST_DEST;
        end else if (wr_lane && hit(address, OFS_DEST)) begin
            dest <= writedata[7:0];
        end else if (exec_fire) begin
            dest <= exec_now.dest;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status <= RST_STATUS;
        end else if (wr_lane && hit(address, OFS_STATUS)) begin
            status <= writedata[7:0];
        end else if (exec_fire) begin
            status <= exec_now.status;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src <= RST_SRC;
        end else if (wr_lane && hit(address, OFS_SRC)) begin
            src <= writedata[7:0];
        end
    end

    // Last issued instruction, read back
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            insn <= RST_INSN;
        end else if (exec_fire) begin
            insn <= writedata[7:0];
        end
    end

    // ==========================================
    // Read data, loaded while the answer waits
    logic [7:0] next_read;

    always_comb begin
        next_read = 8'h00;
        case (address)
            OFS_DEST:   next_read = dest;
            OFS_SRC:    next_read = src;
            OFS_STATUS: next_read = status;
            OFS_INSN:   next_read = insn;
            default:    next_read = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && bus_state == BUS_IDLE) begin
            readdata <= {24'h00_0000, next_read};
        end
    end

    assign dest_value        = dest;
    assign status_value      = status;
    assign global_irq_enable = status[FLAG_I];

    // ==========================================
    // Checks
    logic [7:0] prev_dest;
    logic [7:0] prev_status;
    logic [7:0] prev_src;
    insn_t      prev_insn;
    exec_t      prev_exec;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prev_dest   <= RST_DEST;
            prev_status <= RST_STATUS;
            prev_src    <= RST_SRC;
            prev_insn   <= insn_t'(RST_INSN);
            prev_exec   <= '{dest: RST_DEST, status: RST_STATUS};
        end else begin
            prev_dest   <= dest;
            prev_status <= status;
            prev_src    <= src;
            prev_insn   <= wr_insn;
            prev_exec   <= exec_now;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    a_logical_shift: assert property (
        exec_fire && wr_insn.op == OP_LOGICAL_SHIFT_RIGHT |=>
            dest == {1'b0, prev_dest[7:1]} && status[FLAG_C] == prev_dest[0] && !status[FLAG_N])
        else $error("logical shift right result wrong");

    a_rotate_left: assert property (
        exec_fire && wr_insn.op == OP_ROTATE_LEFT_CARRY |=>
            dest == {prev_dest[6:0], prev_status[FLAG_C]} && status[FLAG_C] == prev_dest[7])
        else $error("rotate left result wrong");

    a_rotate_right: assert property (
        exec_fire && wr_insn.op == OP_ROTATE_RIGHT_CARRY |=>
            dest == {prev_status[FLAG_C], prev_dest[7:1]} && status[FLAG_C] == prev_dest[0])
        else $error("rotate right result wrong");

    a_arith_sign: assert property (
        exec_fire && wr_insn.op == OP_ARITH_SHIFT_RIGHT |=>
            dest == {prev_dest[7], prev_dest[7:1]} && status[FLAG_C] == prev_dest[0])
        else $error("arithmetic shift right result wrong");

    a_shift_flags: assert property (
        exec_fire && (wr_insn.op inside {OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
                                         OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT}) |=>
            status[FLAG_Z] == (dest == 8'h00) && status[FLAG_N] == dest[7]
            && status[FLAG_V] == (status[FLAG_N] ^ status[FLAG_C])
            && status[7:4] == prev_status[7:4])
        else $error("shift flags wrong");

    a_swap_nibbles: assert property (
        exec_fire && wr_insn.op == OP_SWAP |=>
            dest == {prev_dest[3:0], prev_dest[7:4]} && status == prev_status)
        else $error("nibble swap wrong");

    a_bit_set_clear: assert property (
        exec_fire && (wr_insn.op inside {OP_STATUS_BIT_SET, OP_STATUS_BIT_CLEAR}) |=>
            status[prev_insn.bit_idx] == (prev_insn.op == OP_STATUS_BIT_SET)
            && (status ^ prev_status) == ((status ^ prev_status) & (8'h01 << prev_insn.bit_idx)))
        else $error("generic status bit set or clear wrong");

    a_store_bit: assert property (
        exec_fire && wr_insn.op == OP_STORE_BIT_TO_TRANSFER |=>
            status[FLAG_T] == prev_src[prev_insn.bit_idx] && dest == prev_dest)
        else $error("store bit to transfer wrong");

    a_load_bit: assert property (
        exec_fire && wr_insn.op == OP_LOAD_BIT_FROM_TRANSFER |=>
            dest[prev_insn.bit_idx] == prev_status[FLAG_T] && status == prev_status
            && (dest ^ prev_dest) == ((dest ^ prev_dest) & (8'h01 << prev_insn.bit_idx)))
        else $error("load bit from transfer wrong");

    a_carry_only: assert property (
        exec_fire && (wr_insn.op inside {OP_SETC, OP_CLRC}) |=>
            status == {prev_status[7:1], prev_insn.op == OP_SETC})
        else $error("carry set or clear wrong");

    a_irq_enable: assert property (
        exec_fire && (wr_insn.op inside {OP_IRQE, OP_IRQD}) |=>
            global_irq_enable == (prev_insn.op == OP_IRQE) && status[6:0] == prev_status[6:0])
        else $error("interrupt enable bit wrong");

    a_idle_hold: assert property (
        exec_fire && wr_insn.op == OP_NO_OPERATION |=> dest == prev_dest && status == prev_status)
        else $error("no operation changed state");

    a_commit_together: assert property (
        exec_fire |=> dest == prev_exec.dest && status == prev_exec.status)
        else $error("results not committed on one edge");

    a_bus_answer: assert property (
        request |-> ##[0:1] !waitrequest)
        else $error("bus answer late");

endmodule

`default_nettype wire

// >>> src/bitflag_pkg.sv
// Constants and types for the bit and flag instruction unit
package bitflag_pkg;

    // ==========================================
    // Bus and data widths
    localparam int         ADDR_W = 5;
    localparam int         DATA_W = 8;

    // ==========================================
    // Register byte offsets
    localparam logic [4:0] OFS_DEST   = 5'h00;
    localparam logic [4:0] OFS_SRC    = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_INSN   = 5'h0C;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_DEST   = 8'h00;
    localparam logic [7:0] RST_SRC    = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_INSN   = 8'h00;

    // ==========================================
    // Status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ==========================================
    // Operation codes
    typedef enum logic [4:0] {
        OP_NO_OPERATION          = 5'h00, OP_LOGICAL_SHIFT_RIGHT    = 5'h01,
        OP_ROTATE_LEFT_CARRY     = 5'h02, OP_ROTATE_RIGHT_CARRY     = 5'h03,
        OP_ARITH_SHIFT_RIGHT     = 5'h04, OP_SWAP                   = 5'h05,
        OP_STATUS_BIT_SET        = 5'h06, OP_STATUS_BIT_CLEAR       = 5'h07,
        OP_STORE_BIT_TO_TRANSFER = 5'h08, OP_LOAD_BIT_FROM_TRANSFER = 5'h09,
        OP_SETC = 5'h0A, OP_CLRC = 5'h0B,
        OP_SETN = 5'h0C, OP_CLRN = 5'h0D, OP_SETZ = 5'h0E, OP_CLRZ = 5'h0F,
        OP_IRQE = 5'h10, OP_IRQD = 5'h11, OP_SETS = 5'h12, OP_CLRS = 5'h13,
        OP_SETV = 5'h14, OP_CLRV = 5'h15, OP_SETT = 5'h16, OP_CLRT = 5'h17,
        OP_SETH = 5'h18, OP_CLRH = 5'h19
    } op_t;

    typedef struct packed {
        logic [2:0] bit_idx;
        op_t        op;
    } insn_t;

    typedef struct packed {
        logic [7:0] dest;
        logic [7:0] status;
    } exec_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage

// >>> bench/testbench.sv
// Self-checking testbench for the bit and flag instruction unit
`timescale 1ns/10ps
`default_nettype none
module testbench import bitflag_pkg::*;;

    // ==========================================
    // Signals and bookkeeping
    typedef struct packed {
        logic [4:0] op;
        logic [2:0] idx;
        logic [7:0] d;
        logic [7:0] s;
        logic [7:0] st;
        logic [7:0] ed;
        logic [7:0] es;
    } row_t;

    logic              clk               = 1'b0;
    logic              rst_n             = 1'b0;
    logic [ADDR_W-1:0] address           = '0;
    logic              read              = 1'b0;
    logic              write             = 1'b0;
    logic [3:0]        byteenable        = 4'h0;
    logic [31:0]       writedata         = 32'h0;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic [7:0]        dest_value;
    logic [7:0]        status_value;
    logic              global_irq_enable;
    logic [31:0]       q;
    logic [7:0]        m;
    int                num_errors        = 0;
    int                samples_checked   = 0;
    int                cycles            = 0;
    logic [2:0]        flag_pos [8]      = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};

    // Shift, rotate, swap and no-op cases
    row_t              rows [11]         = '{
        '{5'h01, 3'h0, 8'h01, 8'h00, 8'hF0, 8'h00, 8'hFB},
        '{5'h01, 3'h0, 8'h80, 8'h00, 8'h0F, 8'h40, 8'h00},
        '{5'h02, 3'h0, 8'h80, 8'h00, 8'h01, 8'h01, 8'h09},
        '{5'h02, 3'h0, 8'h7F, 8'h00, 8'h00, 8'hFE, 8'h0C},
        '{5'h03, 3'h0, 8'h01, 8'h00, 8'h01, 8'h80, 8'h05},
        '{5'h03, 3'h0, 8'h00, 8'h00, 8'h30, 8'h00, 8'h32},
        '{5'h04, 3'h0, 8'h81, 8'h00, 8'h00, 8'hC0, 8'h05},
        '{5'h04, 3'h0, 8'h01, 8'h00, 8'h10, 8'h00, 8'h1B},
        '{5'h05, 3'h3, 8'hA5, 8'h00, 8'h5A, 8'h5A, 8'h5A},
        '{5'h00, 3'h0, 8'h96, 8'h00, 8'h69, 8'h96, 8'h69},
        '{5'h1F, 3'h7, 8'h3C, 8'h00, 8'hC3, 8'h3C, 8'hC3}
    };

    always #4 clk = ~clk;

    bit_and_flag_instruction_unit u_bit_and_flag_instruction_unit (
        .clk               (clk),
        .rst_n             (rst_n),
        .address           (address),
        .read              (read),
        .write             (write),
        .byteenable        (byteenable),
        .writedata         (writedata),
        .readdata          (readdata),
        .waitrequest       (waitrequest),
        .dest_value        (dest_value),
        .status_value      (status_value),
        .global_irq_enable (global_irq_enable)
    );

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Held until waitrequest is seen low, then released
    task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        read <= rd;
        write <= !rd;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic run(input logic [4:0] op, input logic [2:0] idx, input logic [7:0] d, input logic [7:0] s,
                       input logic [7:0] st, input logic [7:0] ed, input logic [7:0] es);
        bus(1'b0, OFS_DEST, d, 4'hF);
        bus(1'b0, OFS_SRC, s, 4'hF);
        bus(1'b0, OFS_STATUS, st, 4'hF);
        bus(1'b0, OFS_INSN, {idx, op}, 4'h1);
        check({24'h0, dest_value}, {24'h0, ed});
        check({24'h0, status_value}, {24'h0, es});
        check({31'h0, global_irq_enable}, {31'h0, es[7]});
        bus(1'b1, OFS_DEST, 8'h00, 4'hF);
        check(q, {24'h0, ed});
        bus(1'b1, OFS_STATUS, 8'h00, 4'hF);
        check(q, {24'h0, es});
    endtask

    // ==========================================
    // Timeout
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ADDR_W'(4 * i), 8'h00, 4'hF);
            check(q, 32'h0);
        end
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].idx, rows[i].d, rows[i].s, rows[i].st, rows[i].ed, rows[i].es);
        end
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            run(OP_STATUS_BIT_SET, b[2:0], 8'hA5, 8'h00, 8'h00, 8'hA5, m);
            run(OP_STATUS_BIT_CLEAR, b[2:0], 8'hA5, 8'h00, 8'hFF, 8'hA5, ~m);
            run(OP_STORE_BIT_TO_TRANSFER, b[2:0], 8'h00, m, 8'hBF, 8'h00, 8'hFF);
            run(OP_STORE_BIT_TO_TRANSFER, b[2:0], 8'h00, ~m, 8'h40, 8'h00, 8'h00);
            run(OP_LOAD_BIT_FROM_TRANSFER, b[2:0], ~m, 8'h00, 8'h40, 8'hFF, 8'h40);
            run(OP_LOAD_BIT_FROM_TRANSFER, b[2:0], 8'hFF, 8'h00, 8'hBF, ~m, 8'hBF);
        end
        for (int k = 0; k < 8; k++) begin
            m = 8'h01 << flag_pos[k];
            run(5'h0A + 5'(2 * k), 3'h5, 8'h3C, 8'h00, 8'h00, 8'h3C, m);
            run(5'h0B + 5'(2 * k), 3'h2, 8'h3C, 8'h00, 8'hFF, 8'h3C, ~m);
        end
        // Back-to-back rotates see the previous carry
        bus(1'b0, OFS_DEST, 8'h81, 4'hF);
        bus(1'b0, OFS_STATUS, 8'h00, 4'hF);
        bus(1'b0, OFS_INSN, {3'h0, OP_ROTATE_RIGHT_CARRY}, 4'h1);
        bus(1'b0, OFS_INSN, {3'h0, OP_ROTATE_RIGHT_CARRY}, 4'h1);
        check({24'h0, dest_value}, 32'hA0);
        check({24'h0, status_value}, 32'h0C);
        // Lane 0 off and unmapped write change nothing
        bus(1'b0, OFS_INSN, {3'h0, OP_SETC}, 4'hE);
        bus(1'b0, 5'h10, 8'hFF, 4'hF);
        bus(1'b1, OFS_STATUS, 8'h00, 4'hF);
        check(q, 32'h0C);
        bus(1'b1, OFS_INSN, 8'h00, 4'hF);
        check(q, {24'h0, 3'h0, OP_ROTATE_RIGHT_CARRY});
        bus(1'b1, 5'h10, 8'h00, 4'hF);
        check(q, 32'h0);
        // Reset in mid-run
        bus(1'b0, OFS_STATUS, 8'hFF, 4'hF);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check({23'h0, global_irq_enable, dest_value}, 32'h0);
        check({24'h0, status_value}, 32'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, OFS_STATUS, 8'h00, 4'hF);
        check(q, 32'h0);
        conclude();
    end

endmodule
`default_nettype wire
